// File: rtl/ocfr_map.vh
`ifndef OCFR_MAP_VH
`define OCFR_MAP_VH

// Command codes of the three settings
`define OCFR_OC_RESP_CODE 8'hE5
`define OCFR_UC_RESP_CODE 8'hE6
`define OCFR_AVG_OC_CODE 8'hE7

// Reset values
`define OCFR_RESP_RST 8'h80
`define OCFR_AVG_OC_RST 16'hDA80

// Response setting fields
`define OCFR_BEHAV_HI 7
`define OCFR_BEHAV_LO 6
`define OCFR_RETRY_HI 5
`define OCFR_RETRY_LO 3
`define OCFR_BEHAV_DISABLE 2'h2
`define OCFR_RETRY_NONE 3'h0
`define OCFR_RETRY_FOREVER 3'h7
`define OCFR_UNUSED_LOW 3'h7

// Linear-11 fields
`define OCFR_EXP_HI 15
`define OCFR_EXP_LO 11
`define OCFR_MANT_HI 10
`define OCFR_MANT_LO 0
// Fraction bits of the current sample scale (1/256 A)
`define OCFR_SAMPLE_FRAC 8

// Output-current status byte bit positions
`define OCFR_STAT_OC_BIT 7
`define OCFR_STAT_UC_BIT 4

// Retry interval
`define OCFR_RETRY_MS 70
`define OCFR_CLK_KHZ 50000
// Retry interval in core clocks, 70 ms at 50 MHz
`define OCFR_RETRY_CYCLES 22'h3567E0

`endif

// File: rtl/ocfr_fault_resp.v
`timescale 1ns/1ps
`include "ocfr_map.vh"

module ocfr_fault_resp #(
   parameter [21:0] RETRY_CYCLES = `OCFR_RETRY_CYCLES
) (
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Command port from the serial-bus engine
   input wire [7:0] cmdCode,
   input wire cmdWrite,
   input wire cmdRead,
   input wire [15:0] cmdWdata,
   input wire clearFaults,
   output reg [15:0] cmdRdata_q,
   // Per-phase current sampling, bit 0 is phase 0
   input wire [1:0] sampleValid,
   input wire [31:0] sampleValue,
   input wire [1:0] pwmHigh,
   input wire [1:0] blanking,
   input wire [1:0] cycleEnd,
   input wire slopeUp,
   // Fault sources and run conditions
   input wire peakOcFault,
   input wire ucFault,
   input wire controlOn,
   input wire biasOk,
   input wire otherShutdown,
   // Outputs
   output reg alertLineN_q,
   output reg outputEnable_q,
   output reg [7:0] currentStatusByte_q,
   output reg [1:0] phaseOcSeen_q
);

   localparam [1:0] ST_RUN = 2'h0;
   localparam [1:0] ST_HOLD = 2'h1;
   localparam [1:0] ST_WAIT = 2'h2;
   localparam [7:0] RESP_RST = `OCFR_RESP_RST;

   reg [7:3] ocResp_q;
   reg [7:3] ucResp_q;
   reg [15:0] avgOcLimit_q;
   reg ocFlag_q;
   reg ucFlag_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [21:0] retryCnt_q;
   reg [23:0] accSum_q [0:1];
   reg [7:0] accCnt_q [0:1];
   wire [1:0] avgTrip;

   wire ocEvent;
   wire ocFlag_d;
   wire ucFlag_d;
   wire stopRun;
   wire [4:0] expField;
   wire signed [5:0] shiftAmt;
   wire signed [10:0] mantField;
   wire signed [31:0] mantWide;
   wire shiftBig;
   reg signed [31:0] limitQ8;

   // Threshold decode into 1/256 A units
   assign expField = avgOcLimit_q[`OCFR_EXP_HI:`OCFR_EXP_LO];
   assign mantField = avgOcLimit_q[`OCFR_MANT_HI:`OCFR_MANT_LO];
   assign mantWide = {{21{mantField[10]}}, mantField};
   assign shiftAmt = $signed({expField[4], expField}) +
      $signed(6'h08);
   // Exponents that would overflow the product are pinned
   assign shiftBig = ~shiftAmt[5] && (shiftAmt[4:0] > 5'h15);

   // Scaled limit, saturated at the sum range for shifts above 21
   always @* begin
      if (shiftAmt[5]) begin
         limitQ8 = mantWide >>> (-shiftAmt);
      end else if (shiftBig) begin
         limitQ8 = mantField[10] ? 32'hFF800000 : 32'h007FFFFF;
      end else begin
         limitQ8 = mantWide <<< shiftAmt;
      end
   end

   // Per-phase averaging over the sensed interval
   genvar ph;
   generate
      for (ph = 0; ph < 2; ph = ph + 1) begin : g_phase
         wire inWin;
         wire take;
         wire signed [15:0] smp;
         wire signed [23:0] smpWide;
         wire signed [23:0] sumNow;
         wire signed [39:0] lhs;
         wire signed [39:0] rhs;
         // Sense window: D when up-slope, 1-D when down-slope
         assign inWin = (slopeUp ? pwmHigh[ph] : ~pwmHigh[ph]) &
            ~blanking[ph];
         // Full count freezes the sums rather than wrapping
         assign take = sampleValid[ph] && inWin && (accCnt_q[ph] != 8'hFF);
         assign smp = sampleValue[ph*16+15:ph*16];
         assign smpWide = {{8{smp[15]}}, smp};
         assign sumNow = accSum_q[ph];
         // Average above limit tested as sum > limit * count
         assign lhs = {{16{sumNow[23]}}, sumNow};
         assign rhs = limitQ8 * $signed({32'h0, accCnt_q[ph]});

         // Compare once per cycle, only when samples were taken
         assign avgTrip[ph] = cycleEnd[ph] && (accCnt_q[ph] != 8'h00) &&
            (lhs > rhs);

         // Accumulate qualified samples, restart each cycle
         always @(posedge core_clk) begin
            if (sys_rst) begin
               accSum_q[ph] <= 24'h000000;
               accCnt_q[ph] <= 8'h00;
            end else if (cycleEnd[ph]) begin
               accSum_q[ph] <= 24'h000000;
               accCnt_q[ph] <= 8'h00;
            end else if (take) begin
               accSum_q[ph] <= accSum_q[ph] + smpWide;
               accCnt_q[ph] <= accCnt_q[ph] + 8'h01;
            end
         end
      end
   endgenerate

   // Peak and average overcurrent merge into one event
   assign ocEvent = peakOcFault | (|avgTrip);

   // Sticky flags; a new event wins over the clear
   assign ocFlag_d = ocEvent | (ocFlag_q & ~clearFaults);
   assign ucFlag_d = ucFault | (ucFlag_q & ~clearFaults);

   // Sticky fault flags
   always @(posedge core_clk) begin
      if (sys_rst) begin
         ocFlag_q <= 1'b0;
         ucFlag_q <= 1'b0;
      end else begin
         ocFlag_q <= ocFlag_d;
         ucFlag_q <= ucFlag_d;
      end
   end

   // Alert line and status byte, registered from the next flags
   always @(posedge core_clk) begin
      if (sys_rst) begin
         alertLineN_q <= 1'b1;
         currentStatusByte_q <= 8'h00;
      end else begin
         alertLineN_q <= ~(ocFlag_d | ucFlag_d);
         currentStatusByte_q <= 8'h00;
         currentStatusByte_q[`OCFR_STAT_OC_BIT] <= ocFlag_d;
         currentStatusByte_q[`OCFR_STAT_UC_BIT] <= ucFlag_d;
      end
   end

   // Per-phase average trip record, cleared with the flags
   always @(posedge core_clk) begin
      if (sys_rst) begin
         phaseOcSeen_q <= 2'h0;
      end else begin
         phaseOcSeen_q <= avgTrip | (phaseOcSeen_q &
            {2{~clearFaults}});
      end
   end

   // Settings write port
   always @(posedge core_clk) begin
      if (sys_rst) begin
         ocResp_q <= RESP_RST[7:3];
         ucResp_q <= RESP_RST[7:3];
         avgOcLimit_q <= `OCFR_AVG_OC_RST;
      end else if (cmdWrite) begin
         case (cmdCode)
            `OCFR_OC_RESP_CODE: begin
               ocResp_q <= cmdWdata[7:3]; // Low bits ignored
            end
            `OCFR_UC_RESP_CODE: begin
               ucResp_q <= cmdWdata[7:3]; // Low bits ignored
            end
            `OCFR_AVG_OC_CODE: begin
               avgOcLimit_q <= cmdWdata;
            end
            default: ;
         endcase
      end
   end

   // Read port; low bits of a response read 111
   always @(posedge core_clk) begin
      if (sys_rst) begin
         cmdRdata_q <= 16'h0000;
      end else if (cmdRead) begin
         case (cmdCode)
            `OCFR_OC_RESP_CODE:
               cmdRdata_q <= {8'h00, ocResp_q, `OCFR_UNUSED_LOW};
            `OCFR_UC_RESP_CODE:
               cmdRdata_q <= {8'h00, ucResp_q, `OCFR_UNUSED_LOW};
            `OCFR_AVG_OC_CODE: cmdRdata_q <= avgOcLimit_q;
            default: cmdRdata_q <= 16'h0000;
         endcase
      end
   end

   // Response decode for each fault source
   wire ocAct;
   wire ucAct;
   wire ocForever;
   wire ucForever;
   wire anyAct;
   wire allForever;
   assign ocAct = ocEvent && (ocResp_q[`OCFR_BEHAV_HI:`OCFR_BEHAV_LO] ==
      `OCFR_BEHAV_DISABLE);
   assign ucAct = ucFault && (ucResp_q[`OCFR_BEHAV_HI:`OCFR_BEHAV_LO] ==
      `OCFR_BEHAV_DISABLE);
   assign ocForever = ocResp_q[`OCFR_RETRY_HI:`OCFR_RETRY_LO] ==
      `OCFR_RETRY_FOREVER;
   assign ucForever = ucResp_q[`OCFR_RETRY_HI:`OCFR_RETRY_LO] ==
      `OCFR_RETRY_FOREVER;
   assign anyAct = ocAct | ucAct;
   // Any acting source without endless retry forces a hold
   assign allForever = (~ocAct | ocForever) & (~ucAct | ucForever);
   assign stopRun = ~controlOn | ~biasOk | otherShutdown;

   // Shutdown and restart sequencer
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (anyAct) begin
               state_d = allForever ? ST_WAIT : ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (clearFaults && !anyAct) begin
               state_d = ST_RUN;
            end
         end
         ST_WAIT: begin
            if (stopRun || (anyAct && !allForever)) begin
               state_d = ST_HOLD;
            end else if (anyAct) begin
               state_d = ST_WAIT;
            end else if (retryCnt_q == 22'h000001) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_HOLD;
      endcase
   end

   // Sequencer state
   always @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Retry timer, reloaded on every entry or new fault
   always @(posedge core_clk) begin
      if (sys_rst) begin
         retryCnt_q <= 22'h000000;
      end else if (state_d == ST_WAIT &&
                   (state_q != ST_WAIT || anyAct)) begin
         retryCnt_q <= RETRY_CYCLES;
      end else if (retryCnt_q != 22'h000000) begin
         retryCnt_q <= retryCnt_q - 22'h000001;
      end
   end

   // Output runs only in RUN and while every run condition holds
   always @(posedge core_clk) begin
      if (sys_rst) begin
         outputEnable_q <= 1'b0;
      end else begin
         outputEnable_q <= (state_d == ST_RUN) && controlOn &&
            biasOk && !otherShutdown;
      end
   end

endmodule

// File: dv/ocfr_assertions.sv
`timescale 1ns/1ps
module ocfr_checker (
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Command port
   input wire [7:0] cmdCode,
   input wire cmdRead,
   input wire clearFaults,
   input wire [15:0] cmdRdata_q,
   // Fault sources, cycle ends and run conditions
   input wire [1:0] cycleEnd,
   input wire peakOcFault,
   input wire ucFault,
   input wire controlOn,
   input wire biasOk,
   input wire otherShutdown,
   // Outputs
   input wire alertLineN_q,
   input wire outputEnable_q,
   input wire [7:0] currentStatusByte_q,
   input wire [1:0] phaseOcSeen_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Fault response and flag behaviour
   a_oc_flag_alert: assert property (peakOcFault |=>
      currentStatusByte_q[7] && !alertLineN_q) else $error("oc flag late");
   a_uc_flag_set: assert property (ucFault |=> currentStatusByte_q[4])
      else $error("uc flag late");
   a_flag_sticky: assert property (currentStatusByte_q[7] && !clearFaults
      |=> currentStatusByte_q[7]) else $error("oc flag lost");
   a_clear_works: assert property (clearFaults && !peakOcFault && !ucFault
      && cycleEnd == 2'b00 && $past(cycleEnd) == 2'b00
      |=> currentStatusByte_q == 8'h00) else $error("clear failed");
   a_alert_tracks: assert property (alertLineN_q ==
      (currentStatusByte_q == 8'h00)) else $error("alert mismatch");
   a_stop_off: assert property (!controlOn || !biasOk || otherShutdown
      |=> !outputEnable_q) else $error("output ran while stopped");
   a_read_format: assert property (cmdRead && (cmdCode == 8'hE5 ||
      cmdCode == 8'hE6) |=> cmdRdata_q[15:8] == 8'h00 &&
      cmdRdata_q[2:0] == 3'h7) else $error("response read format");
   a_trip_cause: assert property ((phaseOcSeen_q & ~$past(phaseOcSeen_q)
      & ~$past(cycleEnd)) == 2'b00) else $error("trip off cycle end");
   a_trip_flag: assert property ($changed(phaseOcSeen_q)
      && phaseOcSeen_q != 2'b00 |-> currentStatusByte_q[7])
      else $error("trip without flag");
   // Main scenarios
   c_oc: cover property (peakOcFault);
   c_trip: cover property ($rose(phaseOcSeen_q[0]));
   c_retry: cover property ($rose(outputEnable_q) && currentStatusByte_q[7]);
endmodule
bind ocfr_fault_resp ocfr_checker chk (.*);

// File: dv/ocfr_host_model.sv
`timescale 1ns/1ps
module ocfr_host_model (
   // Clock
   input wire core_clk,
   // Command port
   output reg [7:0] cmdCode = 8'h00,
   output reg cmdWrite = 1'b0,
   output reg cmdRead = 1'b0,
   output reg [15:0] cmdWdata = 16'h0000,
   input wire [15:0] cmdRdata_q
);
   // Write strobe held for one edge, entered just after an edge
   task wr(input [7:0] c, input [15:0] d);
      begin
         cmdCode = c;
         cmdWdata = d;
         cmdWrite = 1'b1;
         @(posedge core_clk) #1 cmdWrite = 1'b0;
         @(posedge core_clk) #1;
      end
   endtask
   // Read data lands one edge after the strobe
   task rd(input [7:0] c, output [15:0] d);
      begin
         cmdCode = c;
         cmdRead = 1'b1;
         @(posedge core_clk) #1 cmdRead = 1'b0;
         d = cmdRdata_q;
         @(posedge core_clk) #1;
      end
   endtask
endmodule

// File: dv/test_output_current_fault_response.sv
`timescale 1ns/1ps
module test_output_current_fault_response;
   reg core_clk = 0, sys_rst = 1, clearFaults = 0, slopeUp = 0;
   reg peakOcFault = 0, ucFault = 0, controlOn = 1, biasOk = 1;
   reg otherShutdown = 0;
   reg [1:0] sampleValid = 0, pwmHigh = 0, blanking = 0, cycleEnd = 0;
   reg [31:0] sampleValue = 0;
   wire [7:0] cmdCode, currentStatusByte_q;
   wire cmdWrite, cmdRead, alertLineN_q, outputEnable_q;
   wire [15:0] cmdWdata, cmdRdata_q;
   wire [1:0] phaseOcSeen_q;
   reg [15:0] rd;
   integer errors = 0, num_checks = 0, i;
   // Clock
   always #10 core_clk = ~core_clk;
   ocfr_fault_resp #(.RETRY_CYCLES(22'd20)) DUT (.*);
   ocfr_host_model host (.*);
   // Advance n edges, then drive
   task step(input integer n);
      begin
         repeat (n) @(posedge core_clk);
         #1;
      end
   endtask
   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d errors %0d", num_checks, errors);
         if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // One fault or clear pulse
   task pulse(input integer k);
      begin
         if (k == 0) peakOcFault = 1; else if (k == 1) ucFault = 1;
         else clearFaults = 1;
         step(1);
         {peakOcFault, ucFault, clearFaults} = 3'b000;
         step(1);
      end
   endtask
   // Switching cycle: four samples, the first blanked on phase 0 only
   task cyc(input [15:0] v0, input [15:0] v1);
      begin
         for (i = 0; i < 4; i = i + 1) begin
            blanking = (i == 0) ? 2'b01 : 2'b00;
            sampleValid = 2'b11;
            sampleValue = {v1, (i == 0) ? 16'h7FFF : v0};
            step(1);
         end
         {sampleValid, blanking, cycleEnd} = 6'b000011;
         step(1);
         cycleEnd = 2'b00;
         step(1);
      end
   endtask
   initial begin
      step(5);
      sys_rst = 0;
      step(1);
      host.rd(8'hE5, rd); chk("oc cfg", rd, 16'h0087);
      host.rd(8'hE6, rd); chk("uc cfg", rd, 16'h0087);
      host.rd(8'hE7, rd); chk("avg lim", rd, 16'hDA80);
      host.rd(8'hE8, rd); chk("unmapped", rd, 16'h0000);
      pulse(0);
      chk("status", currentStatusByte_q, 8'h80);
      chk("alert", 16'(alertLineN_q), 0);
      step(40); chk("held", 16'(outputEnable_q), 0);
      pulse(2); chk("cleared", currentStatusByte_q, 0);
      chk("rerun", 16'(outputEnable_q), 1);
      host.wr(8'hE5, 16'h00B8);
      host.rd(8'hE5, rd); chk("oc cfg", rd, 16'h00BF);
      pulse(0); chk("retry off", 16'(outputEnable_q), 0);
      step(15); chk("wait", 16'(outputEnable_q), 0);
      for (i = 0; i < 10 && outputEnable_q !== 1'b1; i = i + 1) step(1);
      if (i == 10) begin
         errors = errors + 1;
         print_verdict;
      end
      chk("flag kept", currentStatusByte_q, 8'h80);
      controlOn = 0; step(2); chk("off", 16'(outputEnable_q), 0);
      controlOn = 1;
      pulse(1); chk("uc", currentStatusByte_q, 8'h90);
      pulse(2);
      cyc(16'h0100, 16'h1500);
      chk("trip", 16'(phaseOcSeen_q), 2);
      chk("avg flag", currentStatusByte_q, 8'h80);
      pulse(2);
      host.wr(8'hE7, 16'h000A);
      slopeUp = 1;
      pwmHigh = 2'b11;
      cyc(16'h0B00, 16'h0900);
      chk("up trip", 16'(phaseOcSeen_q), 1);
      otherShutdown = 1;
      step(25);
      chk("shut", 16'(outputEnable_q), 0);
      otherShutdown = 0;
      step(25);
      chk("stays off", 16'(outputEnable_q), 0);
      pulse(2);
      chk("back on", 16'(outputEnable_q), 1);
      biasOk = 0;
      step(2);
      chk("bias", 16'(outputEnable_q), 0);
      biasOk = 1;
      slopeUp = 0;
      cyc(16'h7FFF, 16'h7FFF);
      chk("no window", 16'(phaseOcSeen_q), 0);
      print_verdict;
   end
endmodule
